// ==== design/uqr_responder.sv ====
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module uqr_responder
  import uqr_pkg::*;
#(
  parameter logic [7:0] UNIT_ADDR = CH_A
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic spoll_req,
  output logic srq,
  output logic [7:0] stb,
  output logic stb_valid
);

  function automatic logic [7:0] dg(input int v, input int p);
    dg = CH_ZERO + 8'((v / p) % 10);
  endfunction

  function automatic logic [3:0] a2d(input logic [7:0] c);
    a2d = c[3:0];
  endfunction

  function automatic logic isdig(input logic [7:0] c);
    isdig = (c >= CH_ZERO) && (c <= CH_ZERO + 8'h09);
  endfunction

  function automatic logic [39:0] fmt_lvl(input uqr_level_t v, input logic bad);
    if (bad)
      fmt_lvl = {CH_PLUS, CH_QRY, CH_QRY, CH_DOT, CH_QRY};
    else
      fmt_lvl = {v.neg ? CH_MINUS : CH_PLUS, dg(v.mag, 100), dg(v.mag, 10), CH_DOT,
        dg(v.mag, 1)};
  endfunction

  function automatic logic [47:0] fmt_volt(input logic [15:0] v);
    fmt_volt = {v[15] ? CH_MINUS : CH_PLUS, dg(v[13:0], 1000), dg(v[13:0], 100), CH_DOT,
      dg(v[13:0], 10), dg(v[13:0], 1)};
  endfunction

  logic [7:0] unit_addr;
  logic srq_en;
  logic remote;
  logic [1:0] algo;
  logic [1:0] act_rx;
  uqr_level_t lvl [2];
  logic [23:0] alrm;
  logic [31:0] vreg [4];
  logic [8:0] hptr;
  logic [23:0] hist [HIST_SLOTS];
  logic [HIST_SLOTS-1:0] hvld;
  uqr_stamp_t ltime;
  uqr_event_t logm [LOG_DEPTH];
  logic [4:0] lwp;
  logic [5:0] lcnt;
  uqr_state_t st;
  logic [7:0] typ;
  logic [23:0] mn;
  logic [1:0] mn_n;
  logic [7:0] prm [MAX_PRM];
  logic [2:0] pn;
  logic ovf;
  uqr_cmd_t rcmd;
  logic [7:0] rtyp;
  logic [23:0] rmn;
  logic [7:0] rq [MAX_PRM];
  logic [8:0] rslot;
  logic [5:0] rsel;
  logic [4:0] ridx;
  logic ractive;
  logic [N_FLT-1:0] seen;
  logic [31:0] rd_mux;
  logic mapped;
  logic [8*BODY_MAX-1:0] body;
  logic [4:0] blen;
  logic [2:0] fidx;

  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire rd = psel & penable & pready & ~pwrite;
  wire [7:0] b = pwdata[7:0];
  wire wr_cmd = wr & (paddr == ADR_CMD);
  wire rd_rply = rd & (paddr == ADR_RPLY);
  wire in_volt = (paddr >= ADR_VOLT) && (paddr < ADR_HPTR) && (paddr[1:0] == 2'h0);
  wire [1:0] vi = 2'((paddr - ADR_VOLT) >> 2);
  wire wr_volt = wr & in_volt;
  wire wr_hdata = wr & (paddr == ADR_HDATA);
  wire wr_push = wr & (paddr == ADR_LPUSH);
  wire [7:0] ch;

  always_comb
  begin
    rd_mux = '0;
    mapped = 1'b1;
    case (paddr)
      ADR_CMD: rd_mux = '0;
      ADR_RPLY: rd_mux = 32'({ractive, ch});
      ADR_CTRL: rd_mux = 32'({act_rx, algo, remote, srq_en, unit_addr});
      ADR_LEVEL: rd_mux = {4'h0, lvl[1], 4'h0, lvl[0]};
      ADR_ALARM: rd_mux = 32'(alrm);
      ADR_HPTR: rd_mux = 32'(hptr);
      ADR_HDATA: rd_mux = 32'(hist[hptr]);
      ADR_LTIME: rd_mux = ltime;
      ADR_LPUSH: rd_mux = '0;
      ADR_STAT: rd_mux = 32'({st, srq, ractive, lcnt});
      default:
      begin
        if (in_volt)
          rd_mux = vreg[vi];
        else
          mapped = 1'b0;
      end
    endcase
  end

  // No wait state: answer registered at the setup cycle, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_addr <= UNIT_ADDR;
      {srq_en, remote, algo, act_rx} <= '0;
      lvl[0] <= '0;
      lvl[1] <= '0;
      alrm <= '0;
      hptr <= '0;
      ltime <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        ADR_CTRL: {act_rx, algo, remote, srq_en, unit_addr} <= pwdata[13:0];
        ADR_LEVEL: {lvl[1], lvl[0]} <= {pwdata[27:16], pwdata[11:0]};
        ADR_ALARM: alrm <= pwdata[23:0];
        ADR_HPTR: hptr <= pwdata[8:0];
        ADR_LTIME: ltime <= pwdata;
        ADR_HDATA: hptr <= (hptr == 9'(HIST_SLOTS - 1)) ? '0 : hptr + 9'h001;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk)
  begin
    if (wr_volt)
      vreg[vi] <= pwdata;
    if (wr_hdata)
      hist[hptr] <= pwdata[23:0];
    if (wr_push)
      logm[lwp] <= {ltime, pwdata[4:0], pwdata[11:8]};
  end

  // Command parser
  wire restart = wr_cmd & (b == CH_OPEN);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= ST_IDLE;
      typ <= '0;
      mn <= '0;
      mn_n <= '0;
      pn <= '0;
      ovf <= 1'b0;
    end
    else if (restart)
      st <= ST_ADDR;
    else if (wr_cmd)
    begin
      case (st)
        ST_IDLE: ;
        ST_ADDR: st <= (b == unit_addr) ? ST_TYPE : ST_IDLE;
        ST_TYPE:
        begin
          typ <= b;
          mn_n <= '0;
          st <= ST_MNEM;
        end
        ST_MNEM:
        begin
          mn <= {mn[15:0], b};
          mn_n <= mn_n + 2'h1;
          pn <= '0;
          ovf <= 1'b0;
          if (mn_n == 2'h2)
            st <= ST_PARM;
        end
        ST_PARM:
        begin
          if (b == CH_CLOSE)
            st <= ST_IDLE;
          else if (pn == 3'(MAX_PRM))
            ovf <= 1'b1;
          else
            pn <= pn + 3'h1;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk)
  begin
    if (wr_cmd && st == ST_PARM && b != CH_CLOSE && pn < 3'(MAX_PRM))
      prm[pn] <= b;
  end

  wire qry = (typ == CH_QRY);
  wire uqr_cmd_t pcmd = (mn == MN_LEVEL) ? C_LEVEL : (mn == MN_ALARM) ? C_ALARM :
    (mn == MN_PAST) ? C_PAST : (mn == MN_EVENT) ? C_EVENT :
    (mn == MN_RAIL) ? C_RAIL : (mn == MN_COND) ? C_COND : C_NONE;
  wire [6:0] pv01 = 7'(a2d(prm[0]) * 10 + a2d(prm[1]));
  wire [6:0] hour = 7'(a2d(prm[1]) * 10 + a2d(prm[2]));
  wire [6:0] minute = 7'(a2d(prm[4]) * 10 + a2d(prm[5]));
  wire [8:0] slot = 9'(hour * SLOTS_PER_HOUR + minute / MIN_STEP);
  wire ok_level = pcmd == C_LEVEL && qry && pn == 3'h1 && (prm[0] == CH_A || prm[0] == CH_B);
  wire ok_alarm = pcmd == C_ALARM && qry && pn == 3'h0;
  wire ok_past = pcmd == C_PAST && qry && pn == 3'(MAX_PRM) && prm[0] == CH_H &&
    prm[3] == CH_N && isdig(prm[1]) && isdig(prm[2]) && isdig(prm[4]) &&
    isdig(prm[5]) && hour <= HOUR_MAX && minute <= MIN_MAX && minute % MIN_STEP == 7'h0;
  wire ok_event = pcmd == C_EVENT && pn == 3'h2 && isdig(prm[0]) && isdig(prm[1]) &&
    (qry ? pv01 <= 7'(lcnt) : pv01 == 7'h0);
  wire ok_rail = pcmd == C_RAIL && qry && pn == 3'h1 && prm[0] >= CH_LA && prm[0] <= CH_LH;
  wire ok_cond = pcmd == C_COND && qry && pn == 3'h0;
  wire done = wr_cmd && st == ST_PARM && b == CH_CLOSE && !ovf;
  wire done_ok = done && (ok_level | ok_alarm | ok_past | ok_event | ok_rail | ok_cond);
  wire clr = done_ok && !qry;
  wire last = ridx == 5'(blen + 5'(PREFIX));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcmd <= C_NONE;
      {rtyp, rmn, rslot, rsel, ridx} <= '0;
      ractive <= 1'b0;
    end
    else if (done_ok)
    begin
      rcmd <= pcmd;
      rtyp <= typ;
      rmn <= mn;
      rslot <= slot;
      rsel <= pv01[5:0];
      ridx <= '0;
      ractive <= 1'b1;
    end
    else if (rd_rply && ractive)
    begin
      ridx <= ridx + 5'h01;
      if (last)
        ractive <= 1'b0;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (done_ok)
      rq <= prm;
  end

  // History and event log state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hvld <= '0;
      lwp <= '0;
      lcnt <= '0;
    end
    else
    begin
      if (wr_hdata)
        hvld[hptr] <= 1'b1;
      if (wr_push)
        lwp <= lwp + 5'h01;
      // erase, a push in the same cycle survives
      if (wr_push)
        lcnt <= clr ? 6'h01 : (lcnt == 6'(LOG_DEPTH)) ? lcnt : lcnt + 6'h01;
      else if (clr)
        lcnt <= '0;
    end
  end

  wire [8*N_CHAN-1:0] chs;
  wire [N_CHAN-1:0] chf;
  for (genvar i = 0; i < N_CHAN; i++)
  begin : g_chan
    wire [1:0] cs = alrm[ALM_CH_LSB + 2 * i +: 2];
    assign chf[i] = cs >= CHS_FLT;
    assign chs[8 * (N_CHAN - 1 - i) +: 8] = CH_ZERO + 8'(chf[i] ? CHS_FLT : cs);
  end

  wire [N_FLT-1:0] flt = {alrm[ALM_PSB], alrm[ALM_PSA], chf, alrm[ALM_RXB], alrm[ALM_RXA]};
  wire rsb = rq[0] == CH_B;
  wire uqr_level_t lv = lvl[rsb];
  wire lv_bad = alrm[rsb ? ALM_RXB : ALM_RXA] | ~lv.ok;
  wire uqr_level_t ha = hist[rslot][11:0];
  wire uqr_level_t hb = hist[rslot][23:12];
  wire uqr_event_t ev = logm[5'(lwp - 5'(lcnt) + 5'(rsel) - 5'h01)];
  wire [2:0] vsel = 3'(rq[0] - CH_LA);
  wire [15:0] vv = vreg[vsel[2:1]][16 * vsel[0] +: 16];
  wire [7:0] actc = act_rx == 2'h0 ? CH_ZERO : act_rx == 2'h1 ? CH_A :
    act_rx == 2'h2 ? CH_B : CH_ZERO + 8'h02;
  wire ev_ch = ev.code >= EV_CHAN_LO && ev.code <= EV_CHAN_HI;

  always_comb
  begin
    body = '0;
    blen = '0;
    case (rcmd)
      C_LEVEL:
      begin
        body = 168'({rq[0], CH_F, fmt_lvl(lv, lv_bad)});
        blen = 5'h07;
      end
      C_ALARM:
      begin
        body = 168'({CH_ZERO + 8'(alrm[ALM_RXA]), CH_ZERO + 8'(alrm[ALM_RXB]), chs,
          CH_ZERO + 8'(alrm[ALM_PSA]), CH_ZERO + 8'(alrm[ALM_PSB])});
        blen = 5'h0E;
      end
      C_PAST:
      begin
        body = 168'({CH_H, rq[1], rq[2], CH_N, rq[4], rq[5],
          CH_A, fmt_lvl(ha, ~hvld[rslot] | ~ha.ok), CH_B, fmt_lvl(hb, ~hvld[rslot] | ~hb.ok)});
        blen = 5'h12;
      end
      C_EVENT:
      begin
        if (rtyp != CH_QRY)
          blen = '0;
        else if (rsel == '0)
        begin
          body = 168'({dg(lcnt, 10), dg(lcnt, 1)});
          blen = 5'h02;
        end
        else
        begin
          body = 168'({rq[0], rq[1], CH_C, dg(ev.ts.yr, 1000), dg(ev.ts.yr, 100),
            dg(ev.ts.yr, 10), dg(ev.ts.yr, 1), dg(ev.ts.mo, 10), dg(ev.ts.mo, 1),
            dg(ev.ts.dy, 10), dg(ev.ts.dy, 1), dg(ev.ts.hr, 10), dg(ev.ts.hr, 1),
            dg(ev.ts.mi, 10), dg(ev.ts.mi, 1), CH_E, dg(ev.code, 10), dg(ev.code, 1)});
          blen = 5'h12;
          if (ev_ch)
          begin
            body = 168'({body[8*18-1:0], CH_C, dg(ev.chan, 10), dg(ev.chan, 1)});
            blen = 5'h15;
          end
        end
      end
      C_RAIL:
      begin
        body = 168'({rq[0], fmt_volt(vv)});
        blen = 5'h07;
      end
      C_COND:
      begin
        body = 168'({CH_L, CH_ZERO + 8'(remote), CH_G, CH_ZERO + 8'(algo), CH_R, actc,
          CH_QRY, CH_ZERO + 8'(|flt[N_FLT-1:2])});
        blen = 5'h08;
      end
      default: ;
    endcase
  end

  wire [4:0] bpos = 5'(blen + 5'(PREFIX) - 5'h01 - ridx);
  wire [1:0] mpos = 2'(5'(PREFIX - 1) - ridx);
  assign ch = ridx == 5'h00 ? CH_OPEN : ridx == 5'h01 ? unit_addr :
    ridx == 5'h02 ? rtyp : ridx < 5'(PREFIX) ? rmn[8 * mpos +: 8] :
    last ? CH_CLOSE : body[8 * bpos +: 8];

  always_comb
  begin
    fidx = '0;
    for (int i = N_FLT - 1; i >= 0; i--)
      if (flt[i])
        fidx = (i > 7) ? IDX_SAT : 3'(i);
  end

  logic [N_FLT-1:0] flt_q;
  // Delivered: lines already standing before this poll
  wire [N_FLT-1:0] told = spoll_req ? (flt & flt_q) : '0;
  wire [N_FLT-1:0] fresh = flt & ~seen & ~told;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      srq <= 1'b0;
      seen <= '0;
      flt_q <= '0;
      stb <= '0;
      stb_valid <= 1'b0;
    end
    else
    begin
      srq <= srq_en & (|flt) & ((srq & ~spoll_req) | (|fresh));
      seen <= (seen & flt) | told;
      flt_q <= flt;
      stb_valid <= spoll_req;
      if (spoll_req)
        stb <= {1'b0, srq, 3'h0, fidx};
    end
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_reply_start: assert property (done_ok |=>
    ractive && ridx == 5'h00 && ch == CH_OPEN)
    else $error("reply did not start");
  chk_reply_addr: assert property (ractive && ridx == 5'h01 |-> ch == unit_addr)
    else $error("reply address wrong");
  chk_level_qm: assert property (ractive && rcmd == C_LEVEL && lv_bad |->
    body[31:0] == {CH_QRY, CH_QRY, CH_DOT, CH_QRY})
    else $error("alarmed level not masked");
  chk_log_clear: assert property (clr && !wr_push |=> lcnt == 6'h00)
    else $error("log not erased");
  chk_log_bound: assert property (lcnt <= 6'(LOG_DEPTH))
    else $error("log count above depth");
  chk_srq_cause: assert property (srq |-> $past(srq_en) && $past(|flt))
    else $error("request without enabled fault");
  chk_srq_drop: assert property (spoll_req && $stable(flt) |=> !srq)
    else $error("request held after poll");
  chk_stb_rqs: assert property (spoll_req |=> stb_valid && stb[STB_RQS] == $past(srq))
    else $error("status byte request bit wrong");
  chk_stb_fixed: assert property (stb_valid |-> !stb[7] && stb[5:3] == 3'h0)
    else $error("status byte fixed bits wrong");
  chk_stb_low: assert property (spoll_req && flt[0] |=> stb[2:0] == 3'h0)
    else $error("lowest fault not reported");

  cov_past: cover property (done_ok && pcmd == C_PAST);
  cov_clear: cover property (clr);
  cov_srq: cover property (!srq ##1 srq ##[1:20] spoll_req);
  cov_reply_end: cover property (rd_rply && ractive && last);
endmodule

// ==== common/uqr_pkg.sv ====
package uqr_pkg;
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_RPLY = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_LEVEL = 8'h0C;
  localparam logic [7:0] ADR_ALARM = 8'h10;
  localparam logic [7:0] ADR_VOLT = 8'h14;
  localparam logic [7:0] ADR_HPTR = 8'h24;
  localparam logic [7:0] ADR_HDATA = 8'h28;
  localparam logic [7:0] ADR_LTIME = 8'h2C;
  localparam logic [7:0] ADR_LPUSH = 8'h30;
  localparam logic [7:0] ADR_STAT = 8'h34;
  localparam logic [7:0] CH_OPEN = 8'h7B;
  localparam logic [7:0] CH_CLOSE = 8'h7D;
  localparam logic [7:0] CH_QRY = 8'h3F;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LH = 8'h68;
  localparam logic [23:0] MN_LEVEL = 24'h445353;
  localparam logic [23:0] MN_ALARM = 24'h414C52;
  localparam logic [23:0] MN_PAST = 24'h484953;
  localparam logic [23:0] MN_EVENT = 24'h4C4F47;
  localparam logic [23:0] MN_RAIL = 24'h564C54;
  localparam logic [23:0] MN_COND = 24'h535441;
  localparam int N_CHAN = 10;
  localparam int N_FLT = 14;
  localparam int HIST_SLOTS = 288;
  localparam int SLOTS_PER_HOUR = 12;
  localparam int LOG_DEPTH = 32;
  localparam int MAX_PRM = 6;
  localparam int BODY_MAX = 21;
  localparam int PREFIX = 6;
  localparam int ALM_RXA = 0;
  localparam int ALM_RXB = 1;
  localparam int ALM_PSA = 2;
  localparam int ALM_PSB = 3;
  localparam int ALM_CH_LSB = 4;
  localparam logic [1:0] CHS_FLT = 2'h2;
  localparam logic [6:0] HOUR_MAX = 7'h17;
  localparam logic [6:0] MIN_MAX = 7'h37;
  localparam logic [6:0] MIN_STEP = 7'h05;
  localparam logic [4:0] EV_CHAN_LO = 5'h18;
  localparam logic [4:0] EV_CHAN_HI = 5'h1B;
  localparam logic [2:0] IDX_SAT = 3'h7;
  localparam int STB_RQS = 6;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_TYPE = 3'b011,
    ST_MNEM = 3'b010, ST_PARM = 3'b110
  } uqr_state_t;
  typedef enum logic [2:0] {
    C_NONE, C_LEVEL, C_ALARM, C_PAST, C_EVENT, C_RAIL, C_COND
  } uqr_cmd_t;
  typedef struct packed {logic ok; logic neg; logic [9:0] mag;} uqr_level_t;
  typedef struct packed {
    logic [11:0] yr; logic [3:0] mo; logic [4:0] dy; logic [4:0] hr; logic [5:0] mi;
  } uqr_stamp_t;
  typedef struct packed {uqr_stamp_t ts; logic [4:0] code; logic [3:0] chan;} uqr_event_t;
endpackage

// ==== verif/uqr_poll_host.sv ====
`timescale 1ns/1ps
module uqr_poll_host
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic srq,
  input wire logic poll_now,
  output logic spoll_req
);
  logic [2:0] hold;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spoll_req <= 1'b0;
      hold <= 3'h0;
    end
    else if (hold != 3'h0)
    begin
      spoll_req <= 1'b0;
      hold <= hold - 3'h1;
    end
    else if (srq || poll_now)
    begin
      spoll_req <= 1'b1;
      hold <= 3'h4;
    end
  end
endmodule

// ==== verif/uqr_responder_tb.sv ====
`timescale 1ns/1ps
module uqr_responder_tb;
  import uqr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic spoll_req;
  logic srq;
  logic [7:0] stb;
  logic stb_valid;
  logic poll_now = 1'b0;
  logic [7:0] last_stb = 8'h00;
  logic [31:0] rd;
  logic er;
  int polls = 0;
  int bad_count = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;

  uqr_responder i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .spoll_req(spoll_req), .srq(srq), .stb(stb), .stb_valid(stb_valid)
  );

  uqr_poll_host i_host (
    .pclk(pclk), .presetn(presetn), .srq(srq), .poll_now(poll_now), .spoll_req(spoll_req)
  );

  // Capture each delivered status byte
  always @(posedge pclk)
  begin
    if (stb_valid === 1'b1)
    begin
      last_stb <= stb;
      polls <= polls + 1;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic string fr(input logic [7:0] ad, input logic [7:0] ty,
                               input logic [23:0] mn, input string t);
    return $sformatf("{%c%c%c%c%c%s}", ad, ty, mn[23:16], mn[15:8], mn[7:0], t);
  endfunction

  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
      apb(ADR_CMD, 1'b1, {24'h0, s[i]});
    @(posedge pclk);
  endtask

  task automatic ask(input logic [7:0] ty, input logic [23:0] mn, input string t,
                     input string b);
    string s;
    s = fr(CH_A, ty, mn, b);
    send(fr(CH_A, ty, mn, t));
    for (int i = 0; i < s.len(); i++)
    begin
      apb(ADR_RPLY, 1'b0, 32'h0);
      cmp({23'h0, rd[8:0]}, {23'h0, 1'b1, s[i]});
    end
    apb(ADR_RPLY, 1'b0, 32'h0);
    cmp({31'h0, rd[8]}, 32'h0);
  endtask

  task automatic no_reply(input string s);
    send(s);
    apb(ADR_STAT, 1'b0, 32'h0);
    cmp({31'h0, rd[6]}, 32'h0);
  endtask

  task automatic wait_poll(input int n);
    while (polls < n)
    begin
      @(posedge pclk);
    end
    @(posedge pclk);
  endtask

  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #300us;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cmp({28'h0, stb_valid, pslverr, pready, srq}, 32'h0);
    cmp({24'h0, stb}, 32'h0);
    apb(8'h3C, 1'b0, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    $display("test reset done");

    apb(ADR_CTRL, 1'b1, 32'h3A41);
    apb(ADR_ALARM, 1'b1, 32'h1);
    ask(CH_QRY, MN_COND, "", "L1G2R2?0");
    cmp({31'h0, srq}, 32'h0);
    apb(ADR_CTRL, 1'b1, 32'h1041);
    apb(ADR_ALARM, 1'b1, 32'h4);
    ask(CH_QRY, MN_COND, "", "L0G0RA?1");
    apb(ADR_CTRL, 1'b1, 32'h2641);
    ask(CH_QRY, MN_COND, "", "L1G1RB?1");
    apb(ADR_CTRL, 1'b1, 32'h0041);
    apb(ADR_ALARM, 1'b1, 32'h10);
    ask(CH_QRY, MN_COND, "", "L0G0R0?0");
    no_reply(fr(CH_B, CH_QRY, MN_COND, ""));
    $display("test condition done");

    apb(ADR_LEVEL, 1'b1, 32'h0C05087B);
    apb(ADR_ALARM, 1'b1, 32'h0);
    ask(CH_QRY, MN_LEVEL, "A", "AF+12.3");
    ask(CH_QRY, MN_LEVEL, "B", "BF-00.5");
    apb(ADR_ALARM, 1'b1, 32'h2);
    ask(CH_QRY, MN_LEVEL, "B", "BF+??.?");
    no_reply(fr(CH_A, 8'h24, MN_LEVEL, "A"));
    $display("test level done");

    apb(ADR_ALARM, 1'b1, 32'h00800019);
    ask(CH_QRY, MN_ALARM, "", "10100000000201");
    apb(ADR_ALARM, 1'b1, 32'h00020086);
    ask(CH_QRY, MN_ALARM, "", "01020000200010");
    $display("test alarm done");

    ask(CH_QRY, MN_PAST, "H23N55", "H23N55A+??.?B+??.?");
    apb(ADR_HPTR, 1'b1, 32'hD);
    apb(ADR_HDATA, 1'b1, 32'h0000080F);
    ask(CH_QRY, MN_PAST, "H01N05", "H01N05A+01.5B+??.?");
    no_reply(fr(CH_A, CH_QRY, MN_PAST, "H01N07"));
    no_reply(fr(CH_A, CH_QRY, MN_PAST, "H24N00"));
    $display("test history done");

    apb(ADR_LTIME, 1'b1, 32'h7D0CFB05);
    apb(ADR_LPUSH, 1'b1, 32'h718);
    apb(ADR_LPUSH, 1'b1, 32'h1);
    ask(CH_QRY, MN_EVENT, "00", "02");
    ask(CH_QRY, MN_EVENT, "01", "01C200012311205E24C07");
    ask(CH_QRY, MN_EVENT, "02", "02C200012311205E01");
    ask(8'h24, MN_EVENT, "00", "");
    no_reply(fr(CH_A, 8'h24, MN_EVENT, "01"));
    ask(CH_QRY, MN_EVENT, "00", "00");
    for (int i = 0; i < 33; i++)
      apb(ADR_LPUSH, 1'b1, 32'h1);
    ask(CH_QRY, MN_EVENT, "00", "32");
    $display("test event log done");

    apb(ADR_VOLT, 1'b1, 32'h85DC0334);
    apb(8'h20, 1'b1, 32'h07D00000);
    ask(CH_QRY, MN_RAIL, "a", "a+08.20");
    ask(CH_QRY, MN_RAIL, "b", "b-15.00");
    ask(CH_QRY, MN_RAIL, "h", "h+20.00");
    $display("test rails done");

    apb(ADR_ALARM, 1'b1, 32'h0);
    apb(ADR_CTRL, 1'b1, 32'h141);
    repeat (3) @(posedge pclk);
    cmp({31'h0, srq}, 32'h0);
    apb(ADR_ALARM, 1'b1, 32'h84);
    wait_poll(1);
    cmp({24'h0, last_stb}, 32'h43);
    repeat (4) @(posedge pclk);
    cmp({31'h0, srq}, 32'h0);
    poll_now <= 1'b1;
    @(posedge pclk);
    poll_now <= 1'b0;
    wait_poll(2);
    cmp({24'h0, last_stb}, 32'h03);
    apb(ADR_ALARM, 1'b1, 32'h85);
    wait_poll(3);
    cmp({24'h0, last_stb}, 32'h40);
    $display("test serial poll done");
    give_verdict();
  end
endmodule
